//--- card_ctl_pkg.sv
// constants and types shared by the plug and play card control register bank
package card_ctl_pkg;

  // -----------------------------------------------------------------
  // host port addresses and widths
  // -----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [11:0] ADDRESS_PORT = 12'h279;
  localparam logic [11:0] WRITE_DATA_PORT = 12'ha79;
  localparam logic [1:0] RPORT_HIGH_BITS = 2'h0;
  localparam logic [1:0] RPORT_LOW_BITS = 2'h3;

  // -----------------------------------------------------------------
  // register indices
  // -----------------------------------------------------------------
  localparam logic [7:0] IDX_READ_PORT_LOCATION = 8'h00;
  localparam logic [7:0] IDX_ISOLATION_BIT_READ = 8'h01;
  localparam logic [7:0] IDX_CARD_CONFIG_COMMAND = 8'h02;
  localparam logic [7:0] IDX_CARD_WAKE_COMMAND = 8'h03;
  localparam logic [7:0] IDX_RESOURCE_BYTE_READ = 8'h04;
  localparam logic [7:0] IDX_RESOURCE_READY_STATUS = 8'h05;
  localparam logic [7:0] IDX_CARD_HANDLE_VALUE = 8'h06;
  localparam logic [7:0] IDX_LOGICAL_UNIT_SELECT = 8'h07;
  localparam logic [7:0] IDX_DEVICE_ACTIVATION = 8'h30;
  localparam logic [7:0] IDX_IO_CONFLICT_CHECK = 8'h31;

  // -----------------------------------------------------------------
  // field positions
  // -----------------------------------------------------------------
  localparam int CMD_LD_RESET_BIT = 0;
  localparam int CMD_KEY_WAIT_BIT = 1;
  localparam int CMD_HANDLE_CLEAR_BIT = 2;
  localparam int ACTIVATE_BIT = 0;
  localparam int RC_ENABLE_BIT = 1;
  localparam int RC_PATTERN_BIT = 0;
  localparam int READY_BIT = 0;

  // -----------------------------------------------------------------
  // values and reset values
  // -----------------------------------------------------------------
  localparam logic [7:0] PATTERN_55 = 8'h55;
  localparam logic [7:0] PATTERN_AA = 8'haa;
  localparam logic [1:0] SENSE_FIRST = 2'h1;
  localparam logic [1:0] SENSE_SECOND = 2'h2;
  localparam logic [7:0] LOGICAL_UNIT_VALUE = 8'h00;
  localparam logic [7:0] RPORT_RESET = 8'h00;
  localparam logic [7:0] HANDLE_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_VALUE = 8'h00;
  localparam int MEM_DESCRIPTORS = 2;

  typedef enum logic [1:0] {key_wait_state, sleep_state, isolate_state, config_state} card_state_t;

endpackage

//--- card_ctl.sv
// plug and play card control register bank on the isa configuration ports
`timescale 1ns/1ns
`default_nettype none

module card_ctl #(
  parameter logic [11:0] ADDR_PORT = card_ctl_pkg::ADDRESS_PORT,
  parameter logic [11:0] WDATA_PORT = card_ctl_pkg::WRITE_DATA_PORT
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [11:0] io_addr,
  input wire logic io_wr,
  input wire logic [7:0] io_wdata,
  input wire logic io_rd,
  input wire logic [1:0] bus_sense,
  output logic [7:0] io_rdata,
  output logic io_rdata_oe,
  input wire logic key_match,
  input wire logic id_bit,
  output logic id_shift,
  input wire logic [7:0] resource_byte,
  input wire logic resource_ready,
  output logic resource_advance,
  output logic resource_rewind,
  input wire logic range_hit,
  output logic device_active,
  output logic range_check_on,
  output logic device_reset,
  output logic [1:0] card_state
);

  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  typedef struct packed {
    card_ctl_pkg::card_state_t state;
    logic [7:0] index;
    logic [7:0] rport;
    logic [7:0] handle;
    logic active;
    logic rc_en;
    logic rc_pat;
    logic rd_prev;
    logic rd_iso;
    logic [7:0] rdata;
    logic oe;
    logic iso_second;
    logic iso_drove;
    logic iso_saw;
    logic id_shift;
    logic res_adv;
    logic res_rewind;
    logic ld_reset;
  } ctl_t;

  ctl_t st_q;
  ctl_t st_d;

  logic rd_start;
  logic rd_end;
  logic on_rport;
  logic in_config_mode;
  logic wr_index;
  logic wr_data;
  logic rd_port_start;
  logic range_read;
  logic [7:0] cmd;

  // -----------------------------------------------------------------
  // port decode
  // -----------------------------------------------------------------
  // the read port address is rebuilt from the stored bits 9..2
  assign on_rport = io_addr ==
    {card_ctl_pkg::RPORT_HIGH_BITS, st_q.rport, card_ctl_pkg::RPORT_LOW_BITS};
  assign in_config_mode = st_q.state != card_ctl_pkg::key_wait_state;
  assign rd_start = io_rd && !st_q.rd_prev;
  assign rd_end = !io_rd && st_q.rd_prev;
  assign wr_index = io_wr && in_config_mode && io_addr == ADDR_PORT;
  assign wr_data = io_wr && in_config_mode && io_addr == WDATA_PORT;
  assign rd_port_start = rd_start && in_config_mode && on_rport;
  // range check answers only while the device is inactive
  assign range_read = rd_start && range_hit && st_q.rc_en && !st_q.active;
  assign cmd = io_wdata;

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.rd_prev = io_rd;
    // one-cycle strobes fall back every cycle
    st_d.id_shift = 1'b0;
    st_d.res_adv = 1'b0;
    st_d.res_rewind = 1'b0;
    st_d.ld_reset = 1'b0;
    if (!io_rd) begin
      st_d.oe = 1'b0;
    end

    // initiation key opens the configuration ports
    if (key_match && st_q.state == card_ctl_pkg::key_wait_state) begin
      st_d.state = card_ctl_pkg::sleep_state;
    end

    // index selection
    if (wr_index) begin
      st_d.index = io_wdata;
    end

    // writes through the write data port take effect at the next clock edge
    if (wr_data) begin
      case (st_q.index)
        card_ctl_pkg::IDX_READ_PORT_LOCATION: begin
          st_d.rport = io_wdata;
        end
        card_ctl_pkg::IDX_CARD_CONFIG_COMMAND: begin
          // command bits act once and are never stored
          if (cmd[card_ctl_pkg::CMD_LD_RESET_BIT]) begin
            st_d.active = 1'b0;
            st_d.rc_en = 1'b0;
            st_d.rc_pat = 1'b0;
            st_d.ld_reset = 1'b1;
          end
          if (cmd[card_ctl_pkg::CMD_KEY_WAIT_BIT]) begin
            st_d.state = card_ctl_pkg::key_wait_state;
          end
          if (cmd[card_ctl_pkg::CMD_HANDLE_CLEAR_BIT]) begin
            st_d.handle = card_ctl_pkg::HANDLE_RESET;
          end
        end
        card_ctl_pkg::IDX_CARD_WAKE_COMMAND: begin
          st_d.res_rewind = 1'b1;
          st_d.iso_second = 1'b0;
          if (io_wdata == st_q.handle) begin
            if (st_q.state == card_ctl_pkg::sleep_state) begin
              st_d.state = (io_wdata == 8'h00) ? card_ctl_pkg::isolate_state
                                               : card_ctl_pkg::config_state;
            end
          end else begin
            // a wake for another card puts this one to sleep
            st_d.state = card_ctl_pkg::sleep_state;
          end
        end
        card_ctl_pkg::IDX_CARD_HANDLE_VALUE: begin
          st_d.handle = io_wdata;
          // the isolation winner leaves isolation once it has a handle
          if (st_q.state == card_ctl_pkg::isolate_state) begin
            st_d.state = card_ctl_pkg::config_state;
          end
        end
        card_ctl_pkg::IDX_DEVICE_ACTIVATION: begin
          if (st_q.state == card_ctl_pkg::config_state) begin
            st_d.active = io_wdata[card_ctl_pkg::ACTIVATE_BIT];
          end
        end
        card_ctl_pkg::IDX_IO_CONFLICT_CHECK: begin
          if (st_q.state == card_ctl_pkg::config_state) begin
            st_d.rc_en = io_wdata[card_ctl_pkg::RC_ENABLE_BIT];
            st_d.rc_pat = io_wdata[card_ctl_pkg::RC_PATTERN_BIT];
          end
        end
        default: begin
          // read-only, absent and unmapped indices ignore writes
        end
      endcase
    end

    // reads through the read port; the isolation mark lasts until the read ends
    if (rd_end) begin
      st_d.rd_iso = 1'b0;
    end
    if (rd_port_start) begin
      st_d.oe = 1'b1;
      case (st_q.index)
        card_ctl_pkg::IDX_ISOLATION_BIT_READ: begin
          if (st_q.state == card_ctl_pkg::isolate_state) begin
            st_d.rd_iso = 1'b1;
            if (!st_q.iso_second) begin
              st_d.iso_drove = id_bit;
              st_d.rdata = card_ctl_pkg::PATTERN_55;
              st_d.oe = id_bit;
            end else begin
              st_d.rdata = card_ctl_pkg::PATTERN_AA;
              st_d.oe = st_q.iso_drove;
            end
          end else begin
            st_d.oe = 1'b0;
          end
        end
        card_ctl_pkg::IDX_RESOURCE_BYTE_READ: begin
          st_d.rdata = resource_byte;
          st_d.res_adv = 1'b1;
        end
        card_ctl_pkg::IDX_RESOURCE_READY_STATUS: begin
          st_d.rdata = 8'h00;
          st_d.rdata[card_ctl_pkg::READY_BIT] = resource_ready;
        end
        card_ctl_pkg::IDX_CARD_HANDLE_VALUE: begin
          st_d.rdata = st_q.handle;
        end
        card_ctl_pkg::IDX_LOGICAL_UNIT_SELECT: begin
          st_d.rdata = card_ctl_pkg::LOGICAL_UNIT_VALUE;
        end
        card_ctl_pkg::IDX_DEVICE_ACTIVATION: begin
          st_d.rdata = {7'h00, st_q.active};
        end
        card_ctl_pkg::IDX_IO_CONFLICT_CHECK: begin
          st_d.rdata = {6'h00, st_q.rc_en, st_q.rc_pat};
        end
        default: begin
          // write-only, absent and unmapped indices read as zero
          st_d.rdata = card_ctl_pkg::UNMAPPED_VALUE;
        end
      endcase
    end else if (range_read) begin
      st_d.oe = 1'b1;
      st_d.rdata = st_q.rc_pat ? card_ctl_pkg::PATTERN_55
                               : card_ctl_pkg::PATTERN_AA;
    end

    // a quiet card senses the other cards at the end of each isolation bit read
    if (rd_end && st_q.rd_iso && st_q.state == card_ctl_pkg::isolate_state) begin
      if (!st_q.iso_second) begin
        st_d.iso_second = 1'b1;
        st_d.iso_saw = !st_q.iso_drove && bus_sense == card_ctl_pkg::SENSE_FIRST;
      end else begin
        st_d.iso_second = 1'b0;
        if (!st_q.iso_drove && st_q.iso_saw && bus_sense == card_ctl_pkg::SENSE_SECOND) begin
          st_d.state = card_ctl_pkg::sleep_state;
        end else begin
          st_d.id_shift = 1'b1;
        end
      end
    end
  end

  // -----------------------------------------------------------------
  // registers
  // -----------------------------------------------------------------
  // hardware reset lands in key wait with no handle and inactive
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st_q <= '0;
      st_q.state <= card_ctl_pkg::key_wait_state;
      st_q.handle <= card_ctl_pkg::HANDLE_RESET;
      st_q.rport <= card_ctl_pkg::RPORT_RESET;
      st_q.active <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  // -----------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------
  assign io_rdata = st_q.rdata;
  assign io_rdata_oe = st_q.oe;
  assign id_shift = st_q.id_shift;
  assign resource_advance = st_q.res_adv;
  assign resource_rewind = st_q.res_rewind;
  assign device_active = st_q.active;
  assign range_check_on = st_q.rc_en && !st_q.active;
  assign device_reset = st_q.ld_reset;
  assign card_state = st_q.state;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  rport_load_a: assert property (@(posedge clock) disable iff (!resetn)
    wr_data && st_q.index == card_ctl_pkg::IDX_READ_PORT_LOCATION
    |=> st_q.rport == $past(io_wdata))
    else $error("read port location not loaded");

  ld_reset_a: assert property (@(posedge clock) disable iff (!resetn)
    wr_data && st_q.index == card_ctl_pkg::IDX_CARD_CONFIG_COMMAND && cmd == 8'h01
    |=> !st_q.active && !st_q.rc_en && device_reset && st_q.handle == $past(st_q.handle)
    ##1 !device_reset)
    else $error("logical device reset wrong");

  key_wait_a: assert property (@(posedge clock) disable iff (!resetn)
    wr_data && st_q.index == card_ctl_pkg::IDX_CARD_CONFIG_COMMAND && cmd[1]
    |=> st_q.state == card_ctl_pkg::key_wait_state && $stable(st_q.active))
    else $error("key wait command failed");

  handle_clear_a: assert property (@(posedge clock) disable iff (!resetn)
    wr_data && st_q.index == card_ctl_pkg::IDX_CARD_CONFIG_COMMAND && cmd[2]
    |=> st_q.handle == 8'h00)
    else $error("card handle not cleared");

  wake_state_a: assert property (@(posedge clock) disable iff (!resetn)
    wr_data && st_q.index == card_ctl_pkg::IDX_CARD_WAKE_COMMAND
    && st_q.state == card_ctl_pkg::sleep_state && io_wdata == st_q.handle
    |=> st_q.state == ($past(io_wdata) == 8'h00 ? card_ctl_pkg::isolate_state
                                                 : card_ctl_pkg::config_state))
    else $error("wake went to wrong state");

  wake_rewind_a: assert property (@(posedge clock) disable iff (!resetn)
    wr_data && st_q.index == card_ctl_pkg::IDX_CARD_WAKE_COMMAND
    |=> resource_rewind ##1 !resource_rewind)
    else $error("wake did not rewind resource pointer");

  resource_read_a: assert property (@(posedge clock) disable iff (!resetn)
    rd_port_start && st_q.index == card_ctl_pkg::IDX_RESOURCE_BYTE_READ
    |=> io_rdata == $past(resource_byte) && resource_advance && io_rdata_oe)
    else $error("resource byte read wrong");

  ready_status_a: assert property (@(posedge clock) disable iff (!resetn)
    rd_port_start && st_q.index == card_ctl_pkg::IDX_RESOURCE_READY_STATUS
    |=> io_rdata == {7'h00, $past(resource_ready)})
    else $error("ready status wrong");

  handle_rw_a: assert property (@(posedge clock) disable iff (!resetn)
    wr_data && st_q.index == card_ctl_pkg::IDX_CARD_HANDLE_VALUE
    |=> st_q.handle == $past(io_wdata))
    else $error("card handle write lost");

  unit_zero_a: assert property (@(posedge clock) disable iff (!resetn)
    rd_port_start && st_q.index == card_ctl_pkg::IDX_LOGICAL_UNIT_SELECT
    |=> io_rdata == 8'h00)
    else $error("logical unit read not zero");

  range_pattern_a: assert property (@(posedge clock) disable iff (!resetn)
    range_read && !rd_port_start
    |=> io_rdata_oe && io_rdata == ($past(st_q.rc_pat) ? 8'h55 : 8'haa))
    else $error("range check pattern wrong");

  iso_drive_a: assert property (@(posedge clock) disable iff (!resetn)
    rd_port_start && st_q.index == card_ctl_pkg::IDX_ISOLATION_BIT_READ
    && st_q.state == card_ctl_pkg::isolate_state && !st_q.iso_second
    |=> io_rdata_oe == $past(id_bit) && io_rdata == 8'h55)
    else $error("isolation first read wrong");

endmodule

`default_nettype wire

//--- card_helpers.sv
// far-side model: serial identifier shifter and slow resource byte store
`timescale 1ns/1ns
`default_nettype none
module card_helpers #(
  parameter logic [7:0] ID_BITS = 8'h01,
  parameter int SLOW = 12
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic id_shift,
  input wire logic resource_advance,
  input wire logic resource_rewind,
  output logic id_bit,
  output logic [7:0] resource_byte,
  output logic resource_ready
);
  logic [7:0] id_q;
  logic [7:0] ptr_q;
  int wait_q;
  // identifier leaves lowest bit first; byte is garbage while not ready
  assign id_bit = id_q[0];
  assign resource_ready = (wait_q == 0);
  assign resource_byte = resource_ready ? 8'h10 + ptr_q : ~(8'h10 + ptr_q);
  // slow store: each fetch takes SLOW cycles
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      id_q <= ID_BITS;
      ptr_q <= 8'h00;
      wait_q <= 0;
    end else begin
      if (id_shift)
        id_q <= {1'b0, id_q[7:1]};
      if (resource_rewind) begin
        ptr_q <= 8'h00;
        wait_q <= 0;
      end else if (resource_advance) begin
        ptr_q <= ptr_q + 8'h01;
        wait_q <= SLOW;
      end else if (wait_q != 0)
        wait_q <= wait_q - 1;
    end
  end
endmodule
`default_nettype wire

//--- test_card_ctl.sv
// self-checking bench for the card control register bank
`timescale 1ns/1ns
`default_nettype none
module test_card_ctl;
  localparam logic [11:0] AP = card_ctl_pkg::ADDRESS_PORT;
  localparam logic [11:0] WP = card_ctl_pkg::WRITE_DATA_PORT;
  logic clock, resetn, io_wr, io_rd, key_match, range_hit, io_rdata_oe, id_bit, id_shift, oe;
  logic resource_ready, resource_advance, resource_rewind, device_active, range_check_on;
  logic device_reset;
  logic [11:0] io_addr;
  logic [7:0] io_wdata, io_rdata, resource_byte, d;
  logic [1:0] bus_sense, card_state;
  int fail_count = 0, n_compared = 0, cycles = 0, n_rew = 0, n_adv = 0, n_sh = 0, n_dr = 0;
  card_ctl dut (.clock(clock), .resetn(resetn), .io_addr(io_addr), .io_wr(io_wr),
    .io_wdata(io_wdata), .io_rd(io_rd), .bus_sense(bus_sense), .io_rdata(io_rdata),
    .io_rdata_oe(io_rdata_oe), .key_match(key_match), .id_bit(id_bit), .id_shift(id_shift),
    .resource_byte(resource_byte), .resource_ready(resource_ready),
    .resource_advance(resource_advance), .resource_rewind(resource_rewind),
    .range_hit(range_hit), .device_active(device_active), .range_check_on(range_check_on),
    .device_reset(device_reset), .card_state(card_state));
  card_helpers helpers (.clock(clock), .resetn(resetn), .id_shift(id_shift),
    .resource_advance(resource_advance), .resource_rewind(resource_rewind), .id_bit(id_bit),
    .resource_byte(resource_byte), .resource_ready(resource_ready));
  // -----------------------------------------------------------------
  // clock, pulse counters and hang guard
  // -----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // sampled mid-cycle so each registered pulse is seen once, settled
  always @(negedge clock) begin
    cycles = cycles + 1;
    n_rew = n_rew + int'(resource_rewind === 1'b1);
    n_adv = n_adv + int'(resource_advance === 1'b1);
    n_sh = n_sh + int'(id_shift === 1'b1);
    n_dr = n_dr + int'(device_reset === 1'b1);
    if (cycles == 5000) begin
      fail_count = fail_count + 1;
      results();
    end
  end
  // -----------------------------------------------------------------
  // compare tasks
  // -----------------------------------------------------------------
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t byte %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp1(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic cmp_st(input logic [1:0] got, input card_ctl_pkg::card_state_t exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t state %0d expected %0d", $time, got, exp);
    end
  endtask
  task automatic cmp_n(input int got, input int exp);
    n_compared++;
    if (got != exp) begin
      fail_count++;
      $display("[ERR] %0t pulse count %0d expected %0d", $time, got, exp);
    end
  endtask
  // -----------------------------------------------------------------
  // bus tasks, entered and left at a falling edge
  // -----------------------------------------------------------------
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    io_addr = a;
    io_wdata = v;
    io_wr = 1'b1;
    @(negedge clock);
    io_wr = 1'b0;
    @(negedge clock);
  endtask
  task automatic regw(input logic [7:0] idx, input logic [7:0] v);
    wr(AP, idx);
    wr(WP, v);
  endtask
  // read held two cycles; the other card's sense value stays into the first low cycle
  task automatic rd_at(input logic [11:0] a, input logic [1:0] s, output logic [7:0] v,
    output logic o);
    io_addr = a;
    io_rd = 1'b1;
    bus_sense = s;
    repeat (2) @(negedge clock);
    v = io_rdata;
    o = io_rdata_oe;
    io_rd = 1'b0;
    @(negedge clock);
    bus_sense = 2'h3;
    @(negedge clock);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [1:0] s, output logic [7:0] v,
    output logic o);
    wr(AP, idx);
    rd_at(12'h203, s, v, o);
  endtask
  task automatic kick();
    key_match = 1'b1;
    @(negedge clock);
    key_match = 1'b0;
    @(negedge clock);
  endtask
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // -----------------------------------------------------------------
  // test sequence
  // -----------------------------------------------------------------
  initial begin
    resetn = 1'b0;
    {io_wr, io_rd, key_match, range_hit} = 4'h0;
    io_addr = 12'h000;
    io_wdata = 8'h00;
    bus_sense = 2'h3;
    repeat (5) @(negedge clock);
    cmp_st(card_state, card_ctl_pkg::key_wait_state);
    cmp1(device_active, 1'b0);
    resetn = 1'b1;
    @(negedge clock);
    regw(8'h06, 8'h33);
    kick();
    cmp_st(card_state, card_ctl_pkg::sleep_state);
    regw(8'h00, 8'h80);
    rd(8'h06, 2'h3, d, oe);
    cmp8(d, 8'h00);
    cmp1(oe, 1'b1);
    rd_at(12'h207, 2'h3, d, oe);
    cmp1(oe, 1'b0);
    $display("test reset and read port done");
    regw(8'h03, 8'h00);
    cmp_st(card_state, card_ctl_pkg::isolate_state);
    cmp_n(n_rew, 1);
    rd(8'h01, 2'h3, d, oe);
    cmp8(d, 8'h55);
    cmp1(oe, 1'b1);
    rd(8'h01, 2'h3, d, oe);
    cmp8(d, 8'haa);
    cmp_n(n_sh, 1);
    rd(8'h01, 2'h1, d, oe);
    cmp1(oe, 1'b0);
    rd(8'h01, 2'h2, d, oe);
    cmp1(oe, 1'b0);
    cmp_st(card_state, card_ctl_pkg::sleep_state);
    $display("test isolation done");
    regw(8'h03, 8'h00);
    regw(8'h06, 8'h05);
    cmp_st(card_state, card_ctl_pkg::config_state);
    rd(8'h06, 2'h3, d, oe);
    cmp8(d, 8'h05);
    regw(8'h07, 8'h44);
    rd(8'h07, 2'h3, d, oe);
    cmp8(d, 8'h00);
    rd(8'h02, 2'h3, d, oe);
    cmp8(d, 8'h00);
    rd(8'h50, 2'h3, d, oe);
    cmp8(d, 8'h00);
    $display("test handle and fixed indices done");
    rd(8'h05, 2'h3, d, oe);
    cmp1(d[0], 1'b1);
    rd(8'h04, 2'h3, d, oe);
    cmp8(d, 8'h10);
    cmp_n(n_adv, 1);
    rd(8'h05, 2'h3, d, oe);
    cmp1(d[0], 1'b0);
    for (int i = 0; i < 20 && d[0] !== 1'b1; i++)
      rd(8'h05, 2'h3, d, oe);
    rd(8'h04, 2'h3, d, oe);
    cmp8(d, 8'h11);
    regw(8'h03, 8'h07);
    cmp_st(card_state, card_ctl_pkg::sleep_state);
    regw(8'h03, 8'h05);
    cmp_st(card_state, card_ctl_pkg::config_state);
    rd(8'h05, 2'h3, d, oe);
    cmp1(d[0], 1'b1);
    rd(8'h04, 2'h3, d, oe);
    cmp8(d, 8'h10);
    $display("test resource stream done");
    regw(8'h31, 8'h03);
    cmp1(range_check_on, 1'b1);
    range_hit = 1'b1;
    rd_at(12'h300, 2'h3, d, oe);
    cmp8(d, 8'h55);
    cmp1(oe, 1'b1);
    regw(8'h31, 8'h02);
    rd_at(12'h300, 2'h3, d, oe);
    cmp8(d, 8'haa);
    range_hit = 1'b0;
    regw(8'h31, 8'h00);
    regw(8'h30, 8'h01);
    cmp1(device_active, 1'b1);
    rd(8'h30, 2'h3, d, oe);
    cmp8(d, 8'h01);
    regw(8'h31, 8'h02);
    cmp1(range_check_on, 1'b0);
    range_hit = 1'b1;
    rd_at(12'h300, 2'h3, d, oe);
    cmp1(oe, 1'b0);
    range_hit = 1'b0;
    $display("test activation and range check done");
    regw(8'h02, 8'h01);
    cmp1(device_active, 1'b0);
    cmp_n(n_dr, 1);
    rd(8'h06, 2'h3, d, oe);
    cmp8(d, 8'h05);
    rd(8'h31, 2'h3, d, oe);
    cmp8(d, 8'h00);
    regw(8'h02, 8'h04);
    rd(8'h06, 2'h3, d, oe);
    cmp8(d, 8'h00);
    cmp_n(n_dr, 1);
    regw(8'h06, 8'h09);
    regw(8'h02, 8'h02);
    cmp_st(card_state, card_ctl_pkg::key_wait_state);
    kick();
    rd(8'h06, 2'h3, d, oe);
    cmp8(d, 8'h09);
    $display("test command bits done");
    results();
  end
endmodule
`default_nettype wire
